//--- rtl/sosc_ctrl.sv
`timescale 1ns/1ps
`include "sosc_map.svh"
module sosc_ctrl import sosc_pkg::*; #(
  parameter int SWON_CYC = `SOSC_SWON_MS * `SOSC_CLK_KHZ,
  parameter int SYNC_CYC = `SOSC_SYNC_MS * `SOSC_CLK_KHZ,
  parameter int ILK_MON_CYC = `SOSC_ILK_MON_MS * `SOSC_CLK_KHZ,
  parameter int ILK_CLR_CYC = `SOSC_ILK_CLR_MS * `SOSC_CLK_KHZ
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // self-test and error detection
  input wire logic selfTestDone,
  input wire logic selfTestOk,
  input wire logic errorDetect,
  // decoded safety inputs and start
  input wire sosc_pair_t safeIn,
  input wire logic startIn,
  // configuration
  input wire logic syncEnable,
  input wire logic ilkEnable,
  // outputs
  output sosc_pair_t safeOut,
  output sosc_state_t opState,
  output logic ilkAlert
);
  localparam logic [`SOSC_TMR_W-1:0] TMAX = '1;
  localparam logic [`SOSC_TMR_W-1:0] SWON_LIM = `SOSC_TMR_W'(SWON_CYC - 1);
  localparam logic [`SOSC_TMR_W-1:0] SYNC_LIM = `SOSC_TMR_W'(SYNC_CYC);
  localparam logic [`SOSC_TMR_W-1:0] MON_LIM = `SOSC_TMR_W'(ILK_MON_CYC - 1);
  localparam logic [`SOSC_TMR_W-1:0] CLR_LIM = `SOSC_TMR_W'(ILK_CLR_CYC - 1);
  localparam sosc_regs_t RST = '{st: ST_INIT, default: '0};

  generate
    if (SWON_CYC < 1 || SYNC_CYC < 1 || ILK_MON_CYC < 1 || ILK_CLR_CYC < 1) begin : g_badParam
      $error("sosc_ctrl: all cycle counts must be at least one");
    end
  endgenerate

  sosc_regs_t q;
  sosc_regs_t d;
  logic both;
  logic none;
  logic one;
  logic startRise;
  logic mayEnergize;

  // activation means a level that permits energizing
  assign both = safeIn.actA & safeIn.actB;
  assign none = ~safeIn.actA & ~safeIn.actB;
  assign one = safeIn.actA ^ safeIn.actB;
  // an edge, not a level: a start held across a stop must not re-energize
  assign startRise = startIn & ~q.startPrev;

  always_comb begin
    d = q;
    d.startPrev = startIn;
    d.bothPrev = both;
    // time from first channel activation to second
    if (none) begin
      d.syncCnt = '0;
      d.syncOk = 1'h0;
    end else if (one) begin
      d.syncOk = 1'h0;
      if (q.syncCnt != TMAX) begin
        d.syncCnt = q.syncCnt + `SOSC_TMR_W'(1);
      end
    end else if (!q.bothPrev) begin
      d.syncOk = (q.syncCnt <= SYNC_LIM);
    end
    // interlock watch runs only in the run states
    if (!ilkEnable || q.st == ST_INIT || q.st == ST_ERR) begin
      d.ilk = 1'h0;
      d.ilkArm = 1'h0;
      d.ilkMon = 1'h0;
    end else if (q.ilk) begin
      // any activation restarts the off-time count
      if (!none) begin
        d.tmr = '0;
      end else if (q.tmr >= CLR_LIM) begin
        d.ilk = 1'h0;
        d.tmr = '0;
      end else begin
        d.tmr = q.tmr + `SOSC_TMR_W'(1);
      end
    end else if (q.ilkMon) begin
      if (none) begin
        d.ilkMon = 1'h0;
        d.tmr = '0;
      end else if (both || q.tmr >= MON_LIM) begin
        // re-activation before the second drops is an alert at once
        d.ilk = 1'h1;
        d.ilkMon = 1'h0;
        d.tmr = '0;
      end else begin
        d.tmr = q.tmr + `SOSC_TMR_W'(1);
      end
    end else if (q.ilkArm && one) begin
      d.ilkMon = 1'h1;
      d.ilkArm = 1'h0;
      d.tmr = '0;
    end else begin
      d.ilkArm = both;
    end
    // energize only from fresh start, stable pair, sync and no interlock
    mayEnergize = startRise && both && q.bothPrev
      && (!syncEnable || q.syncOk)
      && !(ilkEnable && (q.ilk || d.ilk));
    case (q.st)
      ST_INIT: begin
        if (q.tmr != TMAX) begin
          d.tmr = q.tmr + `SOSC_TMR_W'(1);
        end
        if (selfTestDone && !selfTestOk) begin
          d.st = ST_ERR;
        end else if (selfTestDone && q.tmr >= SWON_LIM) begin
          d.st = ST_DEEN;
          d.tmr = '0;
        end
      end
      ST_DEEN: begin
        if (mayEnergize) begin
          d.st = ST_ENER;
        end
      end
      ST_ENER: begin
        if (!both) begin
          d.st = ST_DEEN;
        end
      end
      ST_ERR: begin
        d.st = ST_ERR;
      end
      default: begin
        d.st = ST_ERR;
      end
    endcase
    if (errorDetect) begin
      d.st = ST_ERR;
    end
    // outputs follow the next state so they switch on the same edge
    d.out.actA = (d.st == ST_ENER);
    d.out.actB = (d.st == ST_ENER);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  assign safeOut = q.out;
  assign opState = q.st;
  assign ilkAlert = q.ilk;

  property p_initOff;
    @(posedge sys_clk) disable iff (!rst_n) q.st == ST_INIT |-> !safeOut.actA && !safeOut.actB;
  endproperty
  a_initOff: assert property (p_initOff) else $error("outputs on during init");

  property p_initDone;
    @(posedge sys_clk) disable iff (!rst_n)
      q.st == ST_INIT && selfTestDone && selfTestOk && q.tmr >= SWON_LIM && !errorDetect
      |=> q.st == ST_DEEN && !safeOut.actA;
  endproperty
  a_initDone: assert property (p_initDone) else $error("init did not finish");

  property p_error;
    @(posedge sys_clk) disable iff (!rst_n) errorDetect |=> q.st == ST_ERR;
  endproperty
  a_error: assert property (p_error) else $error("error not entered");

  property p_errHold;
    @(posedge sys_clk) disable iff (!rst_n)
      q.st == ST_ERR |=> q.st == ST_ERR && !safeOut.actA && !safeOut.actB;
  endproperty
  a_errHold: assert property (p_errHold) else $error("error state left");

  property p_noStart;
    @(posedge sys_clk) disable iff (!rst_n)
      q.st == ST_DEEN && (!startIn || $past(startIn)) |=> q.st != ST_ENER;
  endproperty
  a_noStart: assert property (p_noStart) else $error("energized without fresh start");

  property p_notActive;
    @(posedge sys_clk) disable iff (!rst_n) q.st == ST_DEEN && !both |=> !safeOut.actA && !safeOut.actB;
  endproperty
  a_notActive: assert property (p_notActive) else $error("energized with inputs off");

  property p_energize;
    @(posedge sys_clk) disable iff (!rst_n)
      q.st == ST_DEEN && startRise && both && q.bothPrev && !syncEnable && !ilkEnable && !errorDetect
      |=> q.st == ST_ENER && safeOut.actA && safeOut.actB;
  endproperty
  a_energize: assert property (p_energize) else $error("outputs not switched on");

  property p_sync;
    @(posedge sys_clk) disable iff (!rst_n)
      q.st == ST_DEEN && syncEnable && !q.syncOk |=> q.st != ST_ENER;
  endproperty
  a_sync: assert property (p_sync) else $error("energized without sync");

  property p_drop;
    @(posedge sys_clk) disable iff (!rst_n)
      q.st == ST_ENER && !both |=> !safeOut.actA && !safeOut.actB && q.st != ST_ENER;
  endproperty
  a_drop: assert property (p_drop) else $error("outputs stayed on");

  property p_ilkBlock;
    @(posedge sys_clk) disable iff (!rst_n) ilkEnable && q.ilk && q.st == ST_DEEN |=> q.st != ST_ENER;
  endproperty
  a_ilkBlock: assert property (p_ilkBlock) else $error("energized under interlock");

  property p_ilkTimeout;
    @(posedge sys_clk) disable iff (!rst_n)
      ilkEnable && q.st == ST_DEEN && q.ilkMon && !q.ilk && one && q.tmr == MON_LIM ##1 !errorDetect
      |-> q.ilk;
  endproperty
  a_ilkTimeout: assert property (p_ilkTimeout) else $error("interlock alert missed");

  property p_ilkHold;
    @(posedge sys_clk) disable iff (!rst_n)
      ilkEnable && q.ilk && !none && q.st != ST_ERR && !errorDetect |=> q.ilk && q.tmr == '0;
  endproperty
  a_ilkHold: assert property (p_ilkHold) else $error("interlock cleared early");
endmodule

//--- rtl/sosc_map.svh
`ifndef SOSC_MAP_SVH
`define SOSC_MAP_SVH
`define SOSC_CLK_KHZ 40000
`define SOSC_ILK_MON_MS 200
`define SOSC_ILK_CLR_MS 1000
`define SOSC_SYNC_MS 500
`define SOSC_SWON_MS 100
`define SOSC_TMR_W 32
`endif

//--- rtl/sosc_pkg.sv
`include "sosc_map.svh"
package sosc_pkg;
  typedef enum logic [3:0] {
    ST_INIT = 4'h1,
    ST_DEEN = 4'h2,
    ST_ENER = 4'h4,
    ST_ERR = 4'h8
  } sosc_state_t;

  typedef struct packed {
    logic actA;
    logic actB;
  } sosc_pair_t;

  typedef struct packed {
    sosc_state_t st;
    sosc_pair_t out;
    logic ilk;
    logic startPrev;
    logic bothPrev;
    logic syncOk;
    logic ilkArm;
    logic ilkMon;
    logic [`SOSC_TMR_W-1:0] tmr;
    logic [`SOSC_TMR_W-1:0] syncCnt;
  } sosc_regs_t;
endpackage

//--- tb/sosc_estop_model.sv
`timescale 1ns/1ps
module sosc_estop_model import sosc_pkg::*; (
  // clock
  input wire logic sys_clk,
  // bench commands
  input wire logic pullA,
  input wire logic pullB,
  input wire logic pressBtn,
  input wire logic weldB,
  // towards the controller
  output sosc_pair_t safeIn,
  output logic startIn
);
  sosc_pair_t cont = '0;
  logic btn = 1'h0;
  assign safeIn = cont;
  assign startIn = btn;
  // contacts move off the sampling edge
  always @(negedge sys_clk) begin
    cont.actA <= pullA;
    // a welded contact ignores the push, only on command
    cont.actB <= pullB | weldB;
    btn <= pressBtn;
  end
endmodule

//--- tb/tb.sv
`timescale 1ns/1ps
module tb import sosc_pkg::*;;
  localparam int SW = 4, SY = 10, MON = 8, CLR = 16;
  logic sys_clk, rst_n, selfTestDone, selfTestOk, errorDetect, syncEnable, ilkEnable;
  logic pullA, pullB, pressBtn, weldB, startIn, ilkAlert;
  sosc_pair_t safeIn, safeOut;
  sosc_state_t opState;
  int errCount = 0;
  int checks = 0;

  sosc_ctrl #(.SWON_CYC(SW), .SYNC_CYC(SY), .ILK_MON_CYC(MON), .ILK_CLR_CYC(CLR)) u_sosc_ctrl (
    .sys_clk(sys_clk), .rst_n(rst_n), .selfTestDone(selfTestDone), .selfTestOk(selfTestOk),
    .errorDetect(errorDetect), .safeIn(safeIn), .startIn(startIn), .syncEnable(syncEnable),
    .ilkEnable(ilkEnable), .safeOut(safeOut), .opState(opState), .ilkAlert(ilkAlert));
  sosc_estop_model u_sosc_estop_model (.sys_clk(sys_clk), .pullA(pullA), .pullB(pullB),
    .pressBtn(pressBtn), .weldB(weldB), .safeIn(safeIn), .startIn(startIn));

  initial begin
    sys_clk = 1'h0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic conclude();
    if (errCount == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic fail(input string what, input logic [3:0] e, input logic [3:0] s);
    errCount++;
    $display("[FAIL] %s expected %h seen %h", what, e, s);
  endtask

  task automatic chkRun(input string what, input sosc_state_t exp);
    sosc_pair_t o;
    o = (exp == ST_ENER) ? 2'h3 : 2'h0;
    checks += 2;
    if (opState !== exp) fail({what, " state"}, exp, opState);
    if (safeOut !== o) fail({what, " outputs"}, 4'(o), 4'(safeOut));
  endtask

  task automatic chkIlk(input string what, input logic exp);
    checks++;
    if (ilkAlert !== exp) fail(what, 4'(exp), 4'(ilkAlert));
  endtask

  task automatic press(input string what, input sosc_state_t exp);
    pressBtn <= 1'h1;
    cyc(2);
    chkRun(what, exp);
    pressBtn <= 1'h0;
    cyc(2);
  endtask

  // two falling edges: one for the contact, one for the controller
  task automatic setIn(input logic a, input logic b);
    pullA <= a;
    pullB <= b;
    cyc(2);
  endtask

  task automatic scnBasic();
    press("start, contacts open", ST_DEEN);
    setIn(1'h1, 1'h0);
    press("start, only A", ST_DEEN);
    setIn(1'h1, 1'h1);
    cyc(4);
    chkRun("no start", ST_DEEN);
    press("energize", ST_ENER);
    setIn(1'h1, 1'h0);
    chkRun("drop B", ST_DEEN);
    pressBtn <= 1'h1;
    setIn(1'h1, 1'h1);
    cyc(2);
    chkRun("start with re-activation", ST_DEEN);
    pressBtn <= 1'h0;
    cyc(2);
    press("fresh start", ST_ENER);
    setIn(1'h0, 1'h1);
    chkRun("drop A", ST_DEEN);
  endtask

  task automatic scnSync();
    syncEnable <= 1'h1;
    setIn(1'h0, 1'h0);
    setIn(1'h1, 1'h0);
    cyc(SY + 2);
    setIn(1'h1, 1'h1);
    press("late channel", ST_DEEN);
    setIn(1'h0, 1'h0);
    setIn(1'h1, 1'h1);
    press("synced channels", ST_ENER);
    setIn(1'h0, 1'h0);
    syncEnable <= 1'h0;
  endtask

  task automatic scnIlk();
    ilkEnable <= 1'h1;
    setIn(1'h1, 1'h1);
    press("arm", ST_ENER);
    setIn(1'h0, 1'h0);
    cyc(MON + 2);
    chkIlk("both released", 1'h0);
    setIn(1'h1, 1'h1);
    press("rearm", ST_ENER);
    weldB <= 1'h1;
    setIn(1'h0, 1'h0);
    chkRun("welded B", ST_DEEN);
    cyc(MON + 3);
    chkIlk("welded timeout", 1'h1);
    setIn(1'h1, 1'h1);
    press("blocked", ST_DEEN);
    weldB <= 1'h0;
    setIn(1'h0, 1'h0);
    cyc(CLR - 4);
    chkIlk("clear early", 1'h1);
    cyc(8);
    chkIlk("cleared", 1'h0);
    setIn(1'h1, 1'h1);
    press("after clear", ST_ENER);
    setIn(1'h0, 1'h1);
    setIn(1'h1, 1'h1);
    cyc(2);
    chkIlk("reactivated", 1'h1);
    ilkEnable <= 1'h0;
    setIn(1'h0, 1'h0);
  endtask

  task automatic scnErr();
    setIn(1'h1, 1'h1);
    press("before error", ST_ENER);
    errorDetect <= 1'h1;
    cyc(1);
    errorDetect <= 1'h0;
    cyc(1);
    chkRun("error pulse", ST_ERR);
    setIn(1'h0, 1'h0);
    setIn(1'h1, 1'h1);
    press("start in error", ST_ERR);
    rst_n <= 1'h0;
    selfTestDone <= 1'h0;
    selfTestOk <= 1'h0;
    cyc(2);
    chkRun("second reset", ST_INIT);
    rst_n <= 1'h1;
    cyc(SW + 2);
    chkRun("self-test pending", ST_INIT);
    selfTestDone <= 1'h1;
    cyc(1);
    chkRun("self-test fail", ST_ERR);
  endtask

  task automatic scnInit();
    chkRun("in reset", ST_INIT);
    rst_n <= 1'h1;
    cyc(SW - 2);
    chkRun("self-test", ST_INIT);
    cyc(3);
    chkRun("switch-on", ST_DEEN);
  endtask

  initial begin
    {rst_n, errorDetect, syncEnable, ilkEnable, pullA, pullB, pressBtn, weldB} = '0;
    selfTestDone = 1'h1;
    selfTestOk = 1'h1;
    cyc(10);
    scnInit();
    scnBasic();
    scnSync();
    scnIlk();
    scnErr();
    conclude();
  end

  // whole run is under two hundred cycles
  initial begin
    repeat (2000) @(posedge sys_clk);
    errCount++;
    conclude();
  end
endmodule
